// ==== rtl/lcsr_pkg.sv ====
// constants shared by the led current setting register bank
package lcsr_pkg;

  // serial link framing
  localparam logic [6:0] DEV_ADDR      = 7'h74;
  localparam logic       WRITE_BIT     = 1'b0;
  localparam logic [6:0] PTR_WRAP      = 7'h7f;
  localparam logic [6:0] PTR_FIRST     = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_FIRST     = 4'h1;
  localparam logic [3:0] BIT_NONE      = 4'h0;

  // byte positions within a write frame
  localparam logic [1:0] BYTE_DEV  = 2'h0;
  localparam logic [1:0] BYTE_PTR  = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;

  // register offsets
  localparam logic [6:0] REG_MAIN  = 7'h04;
  localparam logic [6:0] REG_AUX_D = 7'h05;
  localparam logic [6:0] REG_AUX_E = 7'h06;
  localparam logic [6:0] REG_AUX_F = 7'h07;
  localparam logic [6:0] REG_SUB_A = 7'h08;
  localparam logic [6:0] REG_SUB_B = 7'h09;

  // field layout and reset values
  localparam int         CODE_MSB  = 4;
  localparam int         UPPER_LSB = 5;
  localparam int         UPPER_MSB = 7;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [4:0] CODE_RST  = 5'h00;

  // code decoding, currents in 0.1 mA, voltages in 0.1 V
  localparam logic [4:0] CODE_OFF   = 5'h1f;
  localparam logic [2:0] DIM_OFF    = 3'h7;
  localparam logic [7:0] CODE_INC   = 8'h01;
  localparam logic [7:0] NORM_STEP  = 8'h06;
  localparam logic [7:0] DIM_STEP   = 8'h02;
  localparam logic [7:0] CUR_ZERO   = 8'h00;
  localparam logic [2:0] VD_DEFAULT = 3'h0;
  localparam logic [5:0] BOOST_DEF  = 6'h32;
  localparam logic [5:0] BOOST_BASE = 6'h29;
  localparam logic [5:0] BOOST_STEP = 6'h02;
  localparam logic [5:0] BOOST_NONE = 6'h00;

endpackage

// ==== rtl/lcsr_link.sv ====
// serial write engine running on the link clock
module lcsr_link #(
  parameter logic [6:0] SLAVE_ADDR = lcsr_pkg::DEV_ADDR
) (
  // link clock and reset
  input  wire logic       link_scl,
  input  wire logic       rst_n,
  // data pin
  input  wire logic       link_sda_in,
  output logic            link_sda_out,
  output logic            link_sda_oe,
  // committed byte, held until the next toggle
  output logic            wr_tgl,
  output logic [6:0]      wr_addr,
  output logic [7:0]      wr_data
);

  if (SLAVE_ADDR[6:3] == 4'h0 || SLAVE_ADDR[6:3] == 4'hf) begin : g_bad_addr
    $error("slave address falls in a reserved group");
  end

  typedef struct packed {
    logic       start_seen;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [1:0] byte_idx;
    logic       selected;
    logic       ack_due;
    logic [6:0] ptr;
    logic       tgl;
    logic [6:0] waddr;
    logic [7:0] wdata;
  } lcsr_link_t;

  lcsr_link_t state_reg;
  lcsr_link_t state_next;
  logic       start_tgl_reg;
  logic       oe_reg;
  logic       sda_drv_reg;
  logic [7:0] shifted;

  // start: data falls while the clock is high; the clock is idle then,
  // so this flop is the only way to see a frame begin
  always_ff @(negedge link_sda_in or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl_reg <= 1'b0;
    end else if (link_scl) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    shifted    = {state_reg.shift[6:0], link_sda_in};
    if (start_tgl_reg != state_reg.start_seen) begin
      state_next.start_seen = start_tgl_reg;
      state_next.bit_cnt    = lcsr_pkg::BIT_FIRST;
      state_next.shift      = shifted;
      state_next.byte_idx   = lcsr_pkg::BYTE_DEV;
      state_next.selected   = 1'b1;
      state_next.ack_due    = 1'b0;
    end else if (state_reg.bit_cnt == lcsr_pkg::BITS_PER_BYTE) begin
      // acknowledge clock: the byte is now complete, and acknowledged only if ack_due is set
      state_next.bit_cnt = lcsr_pkg::BIT_NONE;
      state_next.ack_due = 1'b0;
      if (!state_reg.ack_due) begin
        state_next.selected = 1'b0;
      end else if (state_reg.byte_idx == lcsr_pkg::BYTE_DEV) begin
        state_next.byte_idx = lcsr_pkg::BYTE_PTR;
      end else if (state_reg.byte_idx == lcsr_pkg::BYTE_PTR) begin
        state_next.ptr      = state_reg.shift[6:0];
        state_next.byte_idx = lcsr_pkg::BYTE_DATA;
      end else begin
        state_next.waddr = state_reg.ptr;
        state_next.wdata = state_reg.shift;
        state_next.tgl   = ~state_reg.tgl;
        state_next.ptr   = (state_reg.ptr == lcsr_pkg::PTR_WRAP) ? lcsr_pkg::PTR_FIRST
                                                                 : 7'(state_reg.ptr + 7'h01);
      end
    end else begin
      state_next.shift   = shifted;
      state_next.bit_cnt = 4'(state_reg.bit_cnt + 4'h1);
      if (state_reg.bit_cnt == 4'(lcsr_pkg::BITS_PER_BYTE - 4'h1)) begin
        state_next.ack_due = state_reg.selected &&
                             (state_reg.byte_idx != lcsr_pkg::BYTE_DEV ||
                              (shifted[7:1] == SLAVE_ADDR && shifted[0] == lcsr_pkg::WRITE_BIT));
      end
    end
  end

  // async clear: the link clock may never tick while reset is held
  always_ff @(posedge link_scl or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // acknowledge driven low from the falling edge after bit eight
  always_ff @(negedge link_scl or negedge rst_n) begin
    if (!rst_n) begin
      oe_reg      <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else begin
      oe_reg      <= state_reg.ack_due && state_reg.bit_cnt == lcsr_pkg::BITS_PER_BYTE;
      sda_drv_reg <= 1'b0;
    end
  end

  assign link_sda_oe  = oe_reg;
  assign link_sda_out = sda_drv_reg;
  assign wr_tgl       = state_reg.tgl;
  assign wr_addr      = state_reg.waddr;
  assign wr_data      = state_reg.wdata;

endmodule

// ==== rtl/lcsr_top.sv ====
// led current and boost voltage setting register bank
//
// Contract
// - main byte bits 4..0 are the shared normal current for the first three channels.
// - current code n from 0 to 30 gives (n+1) times 0.6 mA.
// - an all-ones current code switches its channel off, zero current.
// - main byte bits 7..5 give dim current, 0.2 mA steps up to 1.4 mA.
// - dim code all ones turns main leds off; host never fades dim setting.
// - offset 05h holds channel d code in bits 4..0, write-only, reset zero.
// - offset 06h holds channel e code in bits 4..0, write-only, reset zero.
// - offset 07h holds channel f code and boost voltage code, reset zero.
// - boost code 0 gives 5.0 V; codes 1 to 7 give 4.3 to 5.5 V.
// - boost code sets the output only in fixed step-up mode.
// - aux channel uses its own code only while its independent bit is set.
// - offset 08h holds sub channel a code in bits 4..0, reset zero.
// - offset 09h holds sub channel b code in bits 4..0, reset zero.
// - sub channel b follows sub channel a code while its independent bit is clear.
module lcsr_top #(
  parameter logic [6:0] SLAVE_ADDR = lcsr_pkg::DEV_ADDR
) (
  // system clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // serial link
  input  wire logic       link_scl,
  input  wire logic       link_sda_in,
  output logic            link_sda_out,
  output logic            link_sda_oe,
  // mode and enable bits from the control registers
  input  wire logic       dim_mode_enable,
  input  wire logic       fixed_boost_select,
  input  wire logic       channel_d_independent_enable,
  input  wire logic       channel_e_independent_enable,
  input  wire logic       channel_f_independent_enable,
  input  wire logic       sub_b_independent_enable,
  // dac setpoints, 0.1 mA units
  output logic [7:0]      main_abc_current,
  output logic [7:0]      backlight_channel_d,
  output logic [7:0]      backlight_channel_e,
  output logic [7:0]      backlight_channel_f,
  output logic [7:0]      sub_backlight_a,
  output logic [7:0]      sub_backlight_b,
  // boost regulator setpoint, 0.1 V units
  output logic [5:0]      boost_target,
  output logic            boost_fixed_active
);

  typedef struct packed {
    logic       tgl_meta;
    logic       tgl_sync;
    logic       tgl_seen;
    logic [7:0] main_byte;
    logic [4:0] aux_d_current_code;
    logic [4:0] aux_e_current_code;
    logic [7:0] aux_f_byte;
    logic [4:0] sub_a_current_code;
    logic [4:0] sub_b_current_code;
    logic [7:0] cur_main;
    logic [7:0] cur_d;
    logic [7:0] cur_e;
    logic [7:0] cur_f;
    logic [7:0] cur_sub_a;
    logic [7:0] cur_sub_b;
    logic [5:0] boost_v;
    logic       boost_fixed;
  } lcsr_state_t;

  lcsr_state_t state_reg;
  lcsr_state_t state_next;
  logic        link_wr_tgl;
  logic [6:0]  link_wr_addr;
  logic [7:0]  link_wr_data;
  logic        fire;
  logic [4:0]  main_normal_current_code;
  logic [2:0]  main_dim_current_code;
  logic [4:0]  aux_f_current_code;
  logic [2:0]  boost_voltage_code;
  logic [7:0]  main_level;

  lcsr_link #(
    .SLAVE_ADDR (SLAVE_ADDR)
  ) u_link (
    .link_scl     (link_scl),
    .rst_n        (rst_n),
    .link_sda_in  (link_sda_in),
    .link_sda_out (link_sda_out),
    .link_sda_oe  (link_sda_oe),
    .wr_tgl       (link_wr_tgl),
    .wr_addr      (link_wr_addr),
    .wr_data      (link_wr_data)
  );

  // normal-step decode; all ones means off
  function automatic logic [7:0] norm_level(input logic [4:0] code);
    logic [7:0] steps;
    steps = 8'({3'h0, code} + lcsr_pkg::CODE_INC);
    if (code == lcsr_pkg::CODE_OFF) begin
      norm_level = lcsr_pkg::CUR_ZERO;
    end else begin
      norm_level = 8'(steps * lcsr_pkg::NORM_STEP);
    end
  endfunction

  function automatic logic [7:0] dim_level(input logic [2:0] code);
    logic [7:0] steps;
    steps = 8'({5'h0, code} + lcsr_pkg::CODE_INC);
    if (code == lcsr_pkg::DIM_OFF) begin
      dim_level = lcsr_pkg::CUR_ZERO;
    end else begin
      dim_level = 8'(steps * lcsr_pkg::DIM_STEP);
    end
  endfunction

  // code 0 is out of sequence with the others
  function automatic logic [5:0] boost_level(input logic [2:0] code);
    if (code == lcsr_pkg::VD_DEFAULT) begin
      boost_level = lcsr_pkg::BOOST_DEF;
    end else begin
      boost_level = 6'(lcsr_pkg::BOOST_BASE + 6'({3'h0, code} * lcsr_pkg::BOOST_STEP));
    end
  endfunction

  assign main_normal_current_code = state_reg.main_byte[lcsr_pkg::CODE_MSB:0];
  assign main_dim_current_code    = state_reg.main_byte[lcsr_pkg::UPPER_MSB:lcsr_pkg::UPPER_LSB];
  assign aux_f_current_code       = state_reg.aux_f_byte[lcsr_pkg::CODE_MSB:0];
  assign boost_voltage_code       = state_reg.aux_f_byte[lcsr_pkg::UPPER_MSB:lcsr_pkg::UPPER_LSB];
  // address and data were set by the link on the same edge as the toggle, two sync stages before it arrives
  assign fire                     = state_reg.tgl_sync != state_reg.tgl_seen;

  always_comb begin
    state_next          = state_reg;
    state_next.tgl_meta = link_wr_tgl;
    state_next.tgl_sync = state_reg.tgl_meta;
    state_next.tgl_seen = state_reg.tgl_sync;
    main_level          = dim_mode_enable ? dim_level(main_dim_current_code)
                                          : norm_level(main_normal_current_code);
    if (fire) begin
      if (link_wr_addr == lcsr_pkg::REG_MAIN) begin
        state_next.main_byte = link_wr_data;
      end else if (link_wr_addr == lcsr_pkg::REG_AUX_D) begin
        state_next.aux_d_current_code = link_wr_data[lcsr_pkg::CODE_MSB:0];
      end else if (link_wr_addr == lcsr_pkg::REG_AUX_E) begin
        state_next.aux_e_current_code = link_wr_data[lcsr_pkg::CODE_MSB:0];
      end else if (link_wr_addr == lcsr_pkg::REG_AUX_F) begin
        state_next.aux_f_byte = link_wr_data;
      end else if (link_wr_addr == lcsr_pkg::REG_SUB_A) begin
        state_next.sub_a_current_code = link_wr_data[lcsr_pkg::CODE_MSB:0];
      end else if (link_wr_addr == lcsr_pkg::REG_SUB_B) begin
        state_next.sub_b_current_code = link_wr_data[lcsr_pkg::CODE_MSB:0];
      end
    end
    state_next.cur_main  = main_level;
    state_next.cur_d     = channel_d_independent_enable ? norm_level(state_reg.aux_d_current_code) : main_level;
    state_next.cur_e     = channel_e_independent_enable ? norm_level(state_reg.aux_e_current_code) : main_level;
    state_next.cur_f     = channel_f_independent_enable ? norm_level(aux_f_current_code) : main_level;
    state_next.cur_sub_a = norm_level(state_reg.sub_a_current_code);
    state_next.cur_sub_b = sub_b_independent_enable ? norm_level(state_reg.sub_b_current_code)
                                                    : norm_level(state_reg.sub_a_current_code);
    state_next.boost_fixed = fixed_boost_select;
    state_next.boost_v     = fixed_boost_select ? boost_level(boost_voltage_code) : lcsr_pkg::BOOST_NONE;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign main_abc_current    = state_reg.cur_main;
  assign backlight_channel_d = state_reg.cur_d;
  assign backlight_channel_e = state_reg.cur_e;
  assign backlight_channel_f = state_reg.cur_f;
  assign sub_backlight_a     = state_reg.cur_sub_a;
  assign sub_backlight_b     = state_reg.cur_sub_b;
  assign boost_target        = state_reg.boost_v;
  assign boost_fixed_active  = state_reg.boost_fixed;

  default clocking cb_ref @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_write_to(logic [6:0] a);
    fire && (link_wr_addr == a);
  endsequence

  sequence seq_toggle_seen;
    $changed(state_reg.tgl_sync) && fire;
  endsequence

  chk_shared_normal: assert property (
    (!dim_mode_enable && main_normal_current_code != lcsr_pkg::CODE_OFF) |=>
      main_abc_current == 8'(8'({3'h0, $past(main_normal_current_code)} + lcsr_pkg::CODE_INC) * lcsr_pkg::NORM_STEP))
    else $error("normal current level does not match its code");

  chk_normal_off: assert property (
    (sub_backlight_a == lcsr_pkg::CUR_ZERO && !$past(fire)) |->
      $past(state_reg.sub_a_current_code) == lcsr_pkg::CODE_OFF || !$past(rst_n))
    else $error("zero sub current without an off code");

  chk_off_code: assert property (
    (state_reg.sub_a_current_code == lcsr_pkg::CODE_OFF) |=> sub_backlight_a == lcsr_pkg::CUR_ZERO)
    else $error("off code did not give zero current");

  chk_dim_level: assert property (
    (dim_mode_enable && main_dim_current_code != lcsr_pkg::DIM_OFF) |=>
      main_abc_current == 8'(8'({5'h0, $past(main_dim_current_code)} + lcsr_pkg::CODE_INC) * lcsr_pkg::DIM_STEP))
    else $error("dim current level does not match its code");

  chk_dim_off: assert property (
    (dim_mode_enable && main_dim_current_code == lcsr_pkg::DIM_OFF) |=> main_abc_current == lcsr_pkg::CUR_ZERO)
    else $error("dim off code did not turn main leds off");

  chk_aux_follow: assert property (
    (!channel_d_independent_enable && !channel_e_independent_enable) |=>
      backlight_channel_d == main_abc_current && backlight_channel_e == main_abc_current)
    else $error("shared aux channel does not follow main current");

  chk_aux_own: assert property (
    channel_f_independent_enable |=> backlight_channel_f == norm_level($past(aux_f_current_code)))
    else $error("independent aux channel ignores its own code");

  chk_sub_follow: assert property (
    !sub_b_independent_enable |=> sub_backlight_b == sub_backlight_a)
    else $error("sub channel b does not follow channel a");

  chk_boost_fixed: assert property (
    (fixed_boost_select && boost_voltage_code == lcsr_pkg::VD_DEFAULT) |=> boost_target == lcsr_pkg::BOOST_DEF)
    else $error("boost code zero did not give the default voltage");

  chk_boost_auto: assert property (
    !fixed_boost_select |=> boost_target == lcsr_pkg::BOOST_NONE && !boost_fixed_active)
    else $error("boost setpoint driven outside fixed mode");

  chk_write_d: assert property (
    seq_write_to(lcsr_pkg::REG_AUX_D) |=> state_reg.aux_d_current_code == $past(link_wr_data[4:0]))
    else $error("write to channel d code was lost");

  chk_write_f: assert property (
    seq_write_to(lcsr_pkg::REG_AUX_F) |=> state_reg.aux_f_byte == $past(link_wr_data) ##1
      backlight_channel_f == (channel_f_independent_enable ? norm_level($past(link_wr_data[4:0], 2))
                                                           : main_abc_current) || $past(fire))
    else $error("write to channel f byte did not reach its output");

  chk_no_early_apply: assert property (
    !fire |=> $stable(state_reg.main_byte) && $stable(state_reg.sub_b_current_code))
    else $error("settings changed without a committed byte");

  chk_toggle_fire: assert property (
    seq_toggle_seen |=> !fire)
    else $error("one committed byte applied twice");

  // per-register capture, per-channel and boost decode, and commit timing
  chk_write_main: assert property (
    seq_write_to(lcsr_pkg::REG_MAIN) |=> state_reg.main_byte == $past(link_wr_data))
    else $error("main byte write lost");

  chk_write_e: assert property (
    seq_write_to(lcsr_pkg::REG_AUX_E) |=>
      state_reg.aux_e_current_code == $past(link_wr_data[lcsr_pkg::CODE_MSB:0]))
    else $error("channel e write lost");

  chk_write_sub_a: assert property (
    seq_write_to(lcsr_pkg::REG_SUB_A) |=>
      state_reg.sub_a_current_code == $past(link_wr_data[lcsr_pkg::CODE_MSB:0]))
    else $error("sub a write lost");

  chk_write_sub_b: assert property (
    seq_write_to(lcsr_pkg::REG_SUB_B) |=>
      state_reg.sub_b_current_code == $past(link_wr_data[lcsr_pkg::CODE_MSB:0]))
    else $error("sub b write lost");

  chk_aux_d_own: assert property (
    channel_d_independent_enable |=> backlight_channel_d == norm_level($past(state_reg.aux_d_current_code)))
    else $error("channel d ignores its own code");

  chk_aux_e_own: assert property (
    channel_e_independent_enable |=> backlight_channel_e == norm_level($past(state_reg.aux_e_current_code)))
    else $error("channel e ignores its own code");

  chk_follow_f: assert property (
    !channel_f_independent_enable |=> backlight_channel_f == main_abc_current)
    else $error("shared channel f does not follow main current");

  chk_sub_b_own: assert property (
    sub_b_independent_enable |=> sub_backlight_b == norm_level($past(state_reg.sub_b_current_code)))
    else $error("sub b ignores its own code");

  chk_sub_a_level: assert property (
    state_reg.sub_a_current_code != lcsr_pkg::CODE_OFF |=>
      sub_backlight_a == 8'(8'({3'h0, $past(state_reg.sub_a_current_code)} + lcsr_pkg::CODE_INC) *
                            lcsr_pkg::NORM_STEP))
    else $error("sub a level mismatch");

  chk_aux_e_off: assert property (
    (channel_e_independent_enable && state_reg.aux_e_current_code == lcsr_pkg::CODE_OFF) |=>
      backlight_channel_e == lcsr_pkg::CUR_ZERO)
    else $error("channel e off code gave current");

  chk_main_off: assert property (
    (!dim_mode_enable && main_normal_current_code == lcsr_pkg::CODE_OFF) |=> main_abc_current == lcsr_pkg::CUR_ZERO)
    else $error("main off code gave current");

  chk_boost_level: assert property (
    (fixed_boost_select && boost_voltage_code != lcsr_pkg::VD_DEFAULT) |=>
      boost_target == 6'(lcsr_pkg::BOOST_BASE + 6'({3'h0, $past(boost_voltage_code)} * lcsr_pkg::BOOST_STEP)))
    else $error("boost level mismatch");

  chk_fixed_copy: assert property (
    fixed_boost_select |=> boost_fixed_active)
    else $error("fixed boost flag not shown");

  chk_sync_delay: assert property (
    $changed(link_wr_tgl) |-> ##2 fire)
    else $error("committed byte not seen in time");

  chk_hold_others: assert property (
    !fire |=> $stable(state_reg.aux_f_byte) && $stable(state_reg.aux_d_current_code))
    else $error("channel setting changed without a commit");

endmodule

// ==== verification/lcsr_host_model.sv ====
// behavioural two-wire bus master that writes the register bank
module lcsr_host_model (
  // bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int QUARTER = 40;

  // clock stands high between frames, as on an idle bus
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // works from idle and as a repeated start in mid-frame
  task automatic start_cond();
    sda_low = 1'b0;
    #(QUARTER);
    scl = 1'b1;
    #(QUARTER);
    sda_low = 1'b1;
    #(QUARTER);
    scl = 1'b0;
    #(QUARTER);
  endtask

  // fewer than 8 bits leaves a torn byte with no ack clock
  task automatic send_bits(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      sda_low = ~b[i];
      #(QUARTER);
      scl = 1'b1;
      #(2 * QUARTER);
      scl = 1'b0;
      #(QUARTER);
    end
    if (n == 8) begin
      sda_low = 1'b0;
      #(QUARTER);
      scl = 1'b1;
      #(QUARTER);
      ack = ~sda;
      #(QUARTER);
      scl = 1'b0;
      #(QUARTER);
    end
  endtask

  // plain writes only, no fade sequence is ever issued
  task automatic stop_cond();
    sda_low = 1'b1;
    #(QUARTER);
    scl = 1'b1;
    #(QUARTER);
    sda_low = 1'b0;
    #(QUARTER);
  endtask
endmodule

// ==== verification/lcsr_top_tb.sv ====
// self-checking bench for the led current setting register bank
module lcsr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic       ref_clk;
  logic       rst_n;
  logic       link_scl;
  logic       link_sda_in;
  logic       link_sda_out;
  logic       link_sda_oe;
  logic       host_sda_low;
  logic       dim_mode_enable;
  logic       fixed_boost_select;
  logic       ind_d;
  logic       ind_e;
  logic       ind_f;
  logic       ind_sub_b;
  logic [7:0] main_abc_current;
  logic [7:0] backlight_channel_d;
  logic [7:0] backlight_channel_e;
  logic [7:0] backlight_channel_f;
  logic [7:0] sub_backlight_a;
  logic [7:0] sub_backlight_b;
  logic [5:0] boost_target;
  logic       boost_fixed_active;
  int         bad_count;
  int         samples_checked;

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  // pull-up on the data wire, any party pulling low wins
  assign link_sda_in = (host_sda_low || (link_sda_oe && !link_sda_out)) ? 1'b0 : 1'b1;

  lcsr_host_model lcsr_host_model_i (.scl(link_scl), .sda_low(host_sda_low), .sda(link_sda_in));

  lcsr_top lcsr_top_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_scl(link_scl), .link_sda_in(link_sda_in),
    .link_sda_out(link_sda_out), .link_sda_oe(link_sda_oe), .dim_mode_enable(dim_mode_enable),
    .fixed_boost_select(fixed_boost_select), .channel_d_independent_enable(ind_d),
    .channel_e_independent_enable(ind_e), .channel_f_independent_enable(ind_f),
    .sub_b_independent_enable(ind_sub_b), .main_abc_current(main_abc_current),
    .backlight_channel_d(backlight_channel_d), .backlight_channel_e(backlight_channel_e),
    .backlight_channel_f(backlight_channel_f), .sub_backlight_a(sub_backlight_a),
    .sub_backlight_b(sub_backlight_b), .boost_target(boost_target), .boost_fixed_active(boost_fixed_active)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // fixed wait: a committed byte reaches the outputs within about 5 cycles
  task automatic settle();
    repeat (10) @(negedge ref_clk);
  endtask

  function automatic logic [7:0] cur(input logic [4:0] c);
    return (c == 5'h1f) ? 8'h00 : 8'((c + 1) * 6);
  endfunction

  task automatic set_ind(input logic v);
    ind_d     = v;
    ind_e     = v;
    ind_f     = v;
    ind_sub_b = v;
  endtask

  task automatic write_regs(input logic [7:0] ptr, d0, d1, d2, input int n);
    logic       ack;
    logic [7:0] data [3];
    data = '{d0, d1, d2};
    #7;
    lcsr_host_model_i.start_cond();
    lcsr_host_model_i.send_bits(8'he8, 8, ack);
    check({7'h00, ack}, 8'h01);
    lcsr_host_model_i.send_bits(ptr, 8, ack);
    check({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      lcsr_host_model_i.send_bits(data[i], 8, ack);
      check({7'h00, ack}, 8'h01);
    end
    lcsr_host_model_i.stop_cond();
    settle();
  endtask

  task automatic t_reset();
    check(main_abc_current, 8'h06);
    check(backlight_channel_d, 8'h06);
    check({2'h0, boost_target}, 8'h00);
    check({7'h00, boost_fixed_active}, 8'h00);
    fixed_boost_select = 1'b1;
    set_ind(1'b1);
    settle();
    check(backlight_channel_d, 8'h06);
    check(backlight_channel_e, 8'h06);
    check(backlight_channel_f, 8'h06);
    check(sub_backlight_a, 8'h06);
    check(sub_backlight_b, 8'h06);
    check({2'h0, boost_target}, 8'h32);
    check({7'h00, boost_fixed_active}, 8'h01);
    fixed_boost_select = 1'b0;
    set_ind(1'b0);
    settle();
  endtask

  task automatic t_normal();
    logic [4:0] codes [4];
    codes = '{5'h00, 5'h0f, 5'h1e, 5'h1f};
    foreach (codes[i]) begin
      write_regs(8'h04, {3'h5, codes[i]}, 8'h00, 8'h00, 1);
      check(main_abc_current, cur(codes[i]));
      check(backlight_channel_e, cur(codes[i]));
    end
  endtask

  task automatic t_dim();
    dim_mode_enable = 1'b1;
    for (int k = 0; k < 8; k++) begin
      write_regs(8'h04, {3'(k), 5'h0a}, 8'h00, 8'h00, 1);
      check(main_abc_current, (k == 7) ? 8'h00 : 8'((k + 1) * 2));
    end
    dim_mode_enable = 1'b0;
    settle();
    check(main_abc_current, cur(5'h0a));
  endtask

  task automatic t_aux();
    write_regs(8'h05, 8'he3, 8'h1f, 8'h7e, 3);
    check(backlight_channel_d, cur(5'h0a));
    check(backlight_channel_f, cur(5'h0a));
    set_ind(1'b1);
    settle();
    check(backlight_channel_d, cur(5'h03));
    check(backlight_channel_e, 8'h00);
    check(backlight_channel_f, cur(5'h1e));
    check({2'h0, boost_target}, 8'h00);
    fixed_boost_select = 1'b1;
    for (int k = 0; k < 8; k++) begin
      write_regs(8'h07, {3'(k), 5'h1e}, 8'h00, 8'h00, 1);
      check({2'h0, boost_target}, (k == 0) ? 8'h32 : 8'(41 + 2 * k));
      check(backlight_channel_f, cur(5'h1e));
    end
    fixed_boost_select = 1'b0;
    set_ind(1'b0);
    settle();
  endtask

  task automatic t_sub();
    write_regs(8'h08, 8'he2, 8'h09, 8'h00, 2);
    check(sub_backlight_a, cur(5'h02));
    check(sub_backlight_b, cur(5'h02));
    ind_sub_b = 1'b1;
    settle();
    check(sub_backlight_b, cur(5'h09));
    ind_sub_b = 1'b0;
    settle();
  endtask

  // foreign address, read bit and a torn byte leave settings alone
  task automatic t_refuse();
    logic       ack;
    logic [7:0] devs [2];
    devs = '{8'hea, 8'he9};
    foreach (devs[i]) begin
      lcsr_host_model_i.start_cond();
      lcsr_host_model_i.send_bits(devs[i], 8, ack);
      check({7'h00, ack}, 8'h00);
      lcsr_host_model_i.send_bits(8'h04, 8, ack);
      lcsr_host_model_i.send_bits(8'h00, 8, ack);
      lcsr_host_model_i.stop_cond();
    end
    lcsr_host_model_i.start_cond();
    lcsr_host_model_i.send_bits(8'he8, 8, ack);
    lcsr_host_model_i.send_bits(8'h04, 8, ack);
    lcsr_host_model_i.send_bits(8'h00, 4, ack);
    lcsr_host_model_i.start_cond();
    lcsr_host_model_i.send_bits(8'he8, 8, ack);
    lcsr_host_model_i.send_bits(8'h08, 8, ack);
    lcsr_host_model_i.send_bits(8'h05, 8, ack);
    lcsr_host_model_i.stop_cond();
    settle();
    check(main_abc_current, cur(5'h0a));
    check(sub_backlight_a, cur(5'h05));
    // pointer wraps from 7fh to 00h, so the sixth data byte lands in the main byte
    lcsr_host_model_i.start_cond();
    lcsr_host_model_i.send_bits(8'he8, 8, ack);
    lcsr_host_model_i.send_bits(8'h7f, 8, ack);
    for (int i = 0; i < 6; i++) begin
      lcsr_host_model_i.send_bits((i == 5) ? 8'h0c : 8'h00, 8, ack);
      check({7'h00, ack}, 8'h01);
    end
    lcsr_host_model_i.stop_cond();
    settle();
    check(main_abc_current, cur(5'h0c));
  endtask

  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    rst_n              = 1'b0;
    dim_mode_enable    = 1'b0;
    fixed_boost_select = 1'b0;
    set_ind(1'b0);
    bad_count       = 0;
    samples_checked = 0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    settle();
    t_reset();
    t_normal();
    t_dim();
    t_aux();
    t_sub();
    t_refuse();
    summarize();
  end

  // hang guard, far beyond the longest sequence
  initial begin
    #2000000;
    bad_count++;
    summarize();
  end
endmodule
